// [design/cvs_pkg.sv]
// Package of constants and types for the core and regulator voltage select registers
package cvs_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] TRANSITION_CONTROL_OFFSET                = 8'h05;
  localparam logic [7:0] CORE_VOLTAGE_CODE_OFFSET                 = 8'h06;
  localparam logic [7:0] CORE_SLEW_SELECT_OFFSET                  = 8'h07;
  localparam logic [7:0] LINEAR_REGULATOR_VOLTAGE_CONTROL_OFFSET  = 8'h08;

  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int CORE_CODE_WIDTH            = 5;
  localparam int SLEW_CODE_WIDTH            = 3;
  localparam int REG_CODE_WIDTH             = 3;
  localparam int TRANSITION_START_BIT       = 7;
  localparam int CORE_ADJUST_BIT            = 6;
  localparam int REGULATOR_TWO_CODE_LSB     = 4;
  localparam int REGULATOR_ONE_CODE_LSB     = 0;

  // ----------------------------------------------------------------
  // Reset values and fixed codes
  // ----------------------------------------------------------------
  localparam logic [4:0] CORE_CODE_RESET          = 5'h14;
  localparam logic [2:0] SLEW_CODE_RESET          = 3'h6;
  localparam logic       CORE_ADJUST_RESET        = 1'b1;
  localparam logic [2:0] SLEW_IMMEDIATE           = 3'h7;
  localparam logic [4:0] CORE_CODE_PIN_LOW        = 5'h10;
  localparam logic [4:0] CORE_CODE_PIN_HIGH       = 5'h1f;
  // Regulator default codes per preselect pin pair {a,b}: {one[2:0], two[2:0]}
  localparam logic [5:0] REGULATOR_DEFAULT_00     = 6'h00;
  localparam logic [5:0] REGULATOR_DEFAULT_01     = 6'h09;
  localparam logic [5:0] REGULATOR_DEFAULT_10     = 6'h1b;
  localparam logic [5:0] REGULATOR_DEFAULT_11     = 6'h3f;

  // ----------------------------------------------------------------
  // Timing: one 25 mV code step at the slowest rate of 0.225 mV/us
  // ----------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS            = 10;
  localparam int CODE_STEP_UV               = 25000;
  localparam int SLOWEST_RATE_UV_PER_US     = 225;
  localparam int SLOWEST_STEP_NS            = (CODE_STEP_UV * 1000 + SLOWEST_RATE_UV_PER_US - 1) /
                                              SLOWEST_RATE_UV_PER_US;
  localparam int SLOWEST_STEP_CYCLES        = (SLOWEST_STEP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cvs_reg_req_type;

endpackage

// [design/cvs_step_timer.sv]
// Step timer that paces one core code step at the selected slew rate
`timescale 1ns/1ps
module cvs_step_timer
  import cvs_pkg::*;
#(
  parameter int SLOWEST_CYCLES = SLOWEST_STEP_CYCLES
) (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       run,
  input  wire logic [2:0] slewCode,
  output logic            stepTick
);

  localparam int CW = $clog2(SLOWEST_CYCLES + 1);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic          next_stepTick;
  logic [CW-1:0] period;

  // Each slew code doubles the rate, so the step period halves
  always_comb begin
    period = CW'(SLOWEST_CYCLES) >> slewCode;
    if (period == '0) begin
      period = CW'(1);
    end
    next_count    = count;
    next_stepTick = 1'b0;
    if (!run) begin
      next_count = '0;
    end else if (count + CW'(1) >= period) begin
      next_count    = '0;
      next_stepTick = 1'b1;
    end else begin
      next_count = count + CW'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      count    <= '0;
      stepTick <= 1'b0;
    end else begin
      count    <= next_count;
      stepTick <= next_stepTick;
    end
  end

endmodule

// [design/cvs_core_regs.sv]
// Core voltage code, slew select and regulator voltage registers with ramp control
//
// Overview of operation
// (RULE1) Bits 4 to 0 of the core code register are the converter target, 0.8 V plus 25 mV per code, 11111 = 1.575 V.
// (RULE2) The core code field resets to 10100 (1.3 V) and is readable and writable.
// (RULE3) Lockout, input A low, power-on reset output active or low backup supply return the core code to default.
// (RULE4) A 3-bit slew code sets the ramp rate, 0.225 mV/us doubling per step to 14.4 mV/us, 111 immediate, reset 110.
// (RULE5) Regulator two code at bits 6 to 4 selects 1.05 to 3.3 V.
// (RULE6) Regulator one code selects 1 to 3.15 V.
// (RULE7) Both regulator codes reset from the two preselect pins.
// (RULE8) Setting the transition-start bit ramps the core output to the stored code; the bit self-clears on arrival.
// (RULE9) With core adjust permission 0 the output follows the written code; with 1 it follows the setting pin.
`timescale 1ns/1ps
module cvs_core_regs
  import cvs_pkg::*;
#(
  parameter int SLOWEST_CYCLES = SLOWEST_STEP_CYCLES
) (
  input  wire logic            sys_clk,
  input  wire logic            sys_rst,
  input  wire cvs_reg_req_type regReq,
  output logic [7:0]           regRdata,
  output logic                 regRvalid,
  input  wire logic            undervoltageLockout,
  input  wire logic            inputANeg,
  input  wire logic            powerOnResetOutput,
  input  wire logic            backupSupplyLow,
  input  wire logic            regulatorPreselectPinA,
  input  wire logic            regulatorPreselectPinB,
  input  wire logic            coreSettingPin,
  output logic [4:0]           coreConverterOutput,
  output logic                 rampBusy,
  output logic [2:0]           regulatorOneCode,
  output logic [2:0]           regulatorTwoCode
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int NPINS = 7;
  logic [NPINS-1:0] pinRaw;
  logic [NPINS-1:0] pinMeta;
  logic [NPINS-1:0] pinSync;

  assign pinRaw = {coreSettingPin, regulatorPreselectPinB, regulatorPreselectPinA,
                   backupSupplyLow, powerOnResetOutput, inputANeg, undervoltageLockout};

  always_ff @(posedge sys_clk) begin
    pinMeta <= pinRaw;
    pinSync <= pinMeta;
  end

  logic resetEvent;
  assign resetEvent = pinSync[0] | ~pinSync[1] | pinSync[2] | pinSync[3];

  function automatic logic [5:0] regulatorDefault(input logic [1:0] pins);
    case (pins)
      2'b00:   regulatorDefault = REGULATOR_DEFAULT_00;
      2'b01:   regulatorDefault = REGULATOR_DEFAULT_01;
      2'b10:   regulatorDefault = REGULATOR_DEFAULT_10;
      default: regulatorDefault = REGULATOR_DEFAULT_11;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // One-hot register select, shared by the write decode and the read mux
  function automatic logic [3:0] regSelect(input logic [7:0] addr);
    if (addr == TRANSITION_CONTROL_OFFSET) begin
      regSelect = 4'h1;
    end else if (addr == CORE_VOLTAGE_CODE_OFFSET) begin
      regSelect = 4'h2;
    end else if (addr == CORE_SLEW_SELECT_OFFSET) begin
      regSelect = 4'h4;
    end else if (addr == LINEAR_REGULATOR_VOLTAGE_CONTROL_OFFSET) begin
      regSelect = 4'h8;
    end else begin
      regSelect = 4'h0;
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers and ramp
  // ----------------------------------------------------------------
  logic [4:0] coreCode;
  logic [2:0] slewCode;
  logic       transitionStart;
  logic       coreAdjust;
  logic [4:0] next_coreCode;
  logic [2:0] next_slewCode;
  logic       next_transitionStart;
  logic       next_coreAdjust;
  logic [2:0] next_regulatorOneCode;
  logic [2:0] next_regulatorTwoCode;
  logic [4:0] next_coreConverterOutput;
  logic       next_rampBusy;
  logic [7:0] next_regRdata;
  logic       next_regRvalid;
  logic       stepTick;
  logic [5:0] regDefault;
  logic       wrCore;
  logic       wrSlew;
  logic       wrCtrl;
  logic       wrReg;
  logic [3:0] wrSel;
  logic [3:0] rdSel;

  assign regDefault = regulatorDefault({pinSync[4], pinSync[5]});
  assign wrSel  = regReq.write ? regSelect(regReq.addr) : 4'h0;
  assign rdSel  = regReq.read ? regSelect(regReq.addr) : 4'h0;
  assign wrCtrl = wrSel[0];
  assign wrCore = wrSel[1];
  assign wrSlew = wrSel[2];
  assign wrReg  = wrSel[3];

  // ----------------------------------------------------------------
  // Step pacing
  // ----------------------------------------------------------------
  cvs_step_timer #(
    .SLOWEST_CYCLES (SLOWEST_CYCLES)
  ) u_step_timer (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .run      (transitionStart && !coreAdjust && (coreConverterOutput != coreCode)),
    .slewCode (slewCode),
    .stepTick (stepTick)
  );

  always_comb begin
    next_coreCode            = coreCode;
    next_slewCode            = slewCode;
    next_transitionStart     = transitionStart;
    next_coreAdjust          = coreAdjust;
    next_regulatorOneCode    = regulatorOneCode;
    next_regulatorTwoCode    = regulatorTwoCode;
    next_coreConverterOutput = coreConverterOutput;
    if (wrCore) begin
      next_coreCode = regReq.wdata[CORE_CODE_WIDTH-1:0]; // RULE2
    end
    if (wrSlew) begin
      next_slewCode = regReq.wdata[SLEW_CODE_WIDTH-1:0]; // RULE4
    end
    if (wrReg) begin
      next_regulatorTwoCode = regReq.wdata[REGULATOR_TWO_CODE_LSB +: REG_CODE_WIDTH]; // RULE5
      next_regulatorOneCode = regReq.wdata[REGULATOR_ONE_CODE_LSB +: REG_CODE_WIDTH]; // RULE6
    end
    if (wrCtrl) begin
      next_coreAdjust = regReq.wdata[CORE_ADJUST_BIT];
    end
    // Ramp toward the stored code; arrival clears the start bit
    if (coreAdjust) begin
      next_coreConverterOutput = pinSync[6] ? CORE_CODE_PIN_HIGH : CORE_CODE_PIN_LOW; // RULE9
    end else if (transitionStart) begin
      if (coreConverterOutput == coreCode) begin
        next_transitionStart = 1'b0; // RULE8
      end else if (slewCode == SLEW_IMMEDIATE) begin
        next_coreConverterOutput = coreCode; // RULE4
      end else if (stepTick) begin
        next_coreConverterOutput = (coreConverterOutput < coreCode) ?
                                   coreConverterOutput + 5'h01 : coreConverterOutput - 5'h01; // RULE1
      end
    end
    // A write of the start bit wins over the self-clear
    if (wrCtrl && regReq.wdata[TRANSITION_START_BIT]) begin
      next_transitionStart = 1'b1; // RULE8
    end
    if (resetEvent) begin
      next_coreCode   = CORE_CODE_RESET; // RULE3
      next_coreAdjust = CORE_ADJUST_RESET;
    end
    next_rampBusy = next_transitionStart;
  end

  // ----------------------------------------------------------------
  // Read mux, answered one cycle after the read strobe
  // ----------------------------------------------------------------
  always_comb begin
    next_regRvalid = regReq.read;
    next_regRdata  = 8'h00;
    if (regReq.read) begin
      if (rdSel[1]) begin
        next_regRdata = {3'h0, coreCode};
      end else if (rdSel[2]) begin
        next_regRdata = {5'h00, slewCode};
      end else if (rdSel[0]) begin
        next_regRdata = {transitionStart, coreAdjust, 6'h00};
      end else if (rdSel[3]) begin
        next_regRdata = {1'b0, regulatorTwoCode, 1'b0, regulatorOneCode};
      end
    end
  end

  // ----------------------------------------------------------------
  // Register update
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      coreCode            <= CORE_CODE_RESET; // RULE2
      slewCode            <= SLEW_CODE_RESET; // RULE4
      transitionStart     <= 1'b0;
      coreAdjust          <= CORE_ADJUST_RESET;
      regulatorOneCode    <= regDefault[5:3]; // RULE7
      regulatorTwoCode    <= regDefault[2:0]; // RULE7
      coreConverterOutput <= CORE_CODE_RESET;
      rampBusy            <= 1'b0;
      regRdata            <= 8'h00;
      regRvalid           <= 1'b0;
    end else begin
      coreCode            <= next_coreCode;
      slewCode            <= next_slewCode;
      transitionStart     <= next_transitionStart;
      coreAdjust          <= next_coreAdjust;
      regulatorTwoCode    <= next_regulatorTwoCode;
      regulatorOneCode    <= next_regulatorOneCode;
      coreConverterOutput <= next_coreConverterOutput;
      rampBusy            <= next_rampBusy;
      regRdata            <= next_regRdata;
      regRvalid           <= next_regRvalid;
    end
  end

endmodule

// [testbench/cvs_core_regs_checker.sv]
// Assertion checker for the core voltage select registers
`timescale 1ns/1ps
module cvs_core_regs_checker
  import cvs_pkg::*;
(
  input wire logic            sys_clk,
  input wire logic            sys_rst,
  input wire cvs_reg_req_type regReq,
  input wire logic [7:0]      regRdata,
  input wire logic            regRvalid,
  input wire logic [4:0]      coreConverterOutput,
  input wire logic            rampBusy,
  input wire logic [2:0]      regulatorOneCode,
  input wire logic [2:0]      regulatorTwoCode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic wr8;
  logic goWr;
  assign wr8 = regReq.write && regReq.addr == LINEAR_REGULATOR_VOLTAGE_CONTROL_OFFSET;
  assign goWr = regReq.write && regReq.addr == TRANSITION_CONTROL_OFFSET && regReq.wdata[7];
  AST_RVALID: assert property (regReq.read |=> regRvalid) else $error("read not answered");
  AST_RVALID_LOW: assert property (!regReq.read |=> !regRvalid && regRdata == 8'h00)
    else $error("stray read data");
  AST_UNMAPPED: assert property (regReq.read && !(regReq.addr inside {[8'h05:8'h08]}) |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  AST_RESET_VAL: assert property ($fell(sys_rst) |-> coreConverterOutput == CORE_CODE_RESET && !rampBusy)
    else $error("wrong output after reset");
  AST_REG_WRITE: assert property (wr8 |=> regulatorTwoCode == $past(regReq.wdata[6:4])
    && regulatorOneCode == $past(regReq.wdata[2:0])) else $error("regulator code not written");
  AST_REG_STABLE: assert property (!wr8 |=> $stable(regulatorOneCode) && $stable(regulatorTwoCode))
    else $error("regulator code changed");
  AST_START: assert property (goWr |=> rampBusy) else $error("start bit not set");
  AST_BUSY_CLEAR: assert property ($fell(rampBusy) |-> $stable(coreConverterOutput))
    else $error("busy cleared before arrival");
endmodule
bind cvs_core_regs cvs_core_regs_checker u_chk (.sys_clk, .sys_rst, .regReq, .regRdata, .regRvalid,
  .coreConverterOutput, .rampBusy, .regulatorOneCode, .regulatorTwoCode);

// [testbench/cvs_host_model.sv]
// Host processor model issuing single-byte register requests
`timescale 1ns/1ps
module cvs_host_model
  import cvs_pkg::*;
(
  input  wire logic       sys_clk,
  output cvs_reg_req_type regReq,
  input  wire logic [7:0] regRdata,
  input  wire logic       regRvalid
);
  initial regReq = '0;
  // Released data is inverted so a stale value is never mistaken for a request
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    regReq = '{1'b1, 1'b0, a, d};
    @(negedge sys_clk);
    regReq = '{1'b0, 1'b0, a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge sys_clk);
    regReq = '{1'b0, 1'b1, a, 8'h00};
    @(negedge sys_clk);
    regReq.read = 1'b0;
    d = regRdata;
    v = regRvalid;
  endtask
endmodule

// [testbench/cvs_core_regs_test.sv]
// Self-checking testbench for the core voltage select registers
`timescale 1ns/1ps
module cvs_core_regs_test;
  import cvs_pkg::*;
  logic            sys_clk, sys_rst, pinA, pinB, setPin, rv, rampBusy, regRvalid;
  logic [3:0]      evt;
  logic [4:0]      coreOut;
  logic [2:0]      oneCode, twoCode;
  logic [7:0]      rdat, regRdata;
  cvs_reg_req_type regReq;
  int              num_errors = 0;
  int              samples_checked = 0;
  int              cycles = 0;
  int              n;
  cvs_host_model u_cvs_host_model (.sys_clk, .regReq, .regRdata, .regRvalid);
  cvs_core_regs #(.SLOWEST_CYCLES(16)) u_cvs_core_regs (.sys_clk, .sys_rst, .regReq, .regRdata, .regRvalid,
    .undervoltageLockout(evt[0]), .inputANeg(~evt[1]), .powerOnResetOutput(evt[2]), .backupSupplyLow(evt[3]),
    .regulatorPreselectPinA(pinA), .regulatorPreselectPinB(pinB), .coreSettingPin(setPin),
    .coreConverterOutput(coreOut), .rampBusy, .regulatorOneCode(oneCode), .regulatorTwoCode(twoCode));
  // ------
  // Helpers
  // ------
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    u_cvs_host_model.rd(a, rdat, rv);
    check({rv, rdat}, {1'b1, exp});
  endtask
  task automatic go(output int cnt);
    u_cvs_host_model.wr(TRANSITION_CONTROL_OFFSET, 8'h80);
    cnt = 0;
    do begin
      @(negedge sys_clk);
      cnt++;
    end while (rampBusy !== 1'b0 && cnt < 2000);
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ------
  // Scenarios
  // ------
  task automatic testResetValues();
    rdchk(CORE_VOLTAGE_CODE_OFFSET, 8'h14);
    rdchk(CORE_SLEW_SELECT_OFFSET, 8'h06);
    rdchk(TRANSITION_CONTROL_OFFSET, 8'h40);
    rdchk(LINEAR_REGULATOR_VOLTAGE_CONTROL_OFFSET, 8'h33);
    check({4'h0, coreOut}, 9'h01f);
  endtask
  task automatic testAccess();
    u_cvs_host_model.wr(CORE_VOLTAGE_CODE_OFFSET, 8'hff);
    rdchk(CORE_VOLTAGE_CODE_OFFSET, 8'h1f);
    u_cvs_host_model.wr(CORE_SLEW_SELECT_OFFSET, 8'hff);
    rdchk(CORE_SLEW_SELECT_OFFSET, 8'h07);
    u_cvs_host_model.wr(8'h09, 8'hff);
    rdchk(8'h09, 8'h00);
    for (int i = 0; i < 8; i++) begin
      u_cvs_host_model.wr(LINEAR_REGULATOR_VOLTAGE_CONTROL_OFFSET, {1'b1, i[2:0], 1'b1, ~i[2:0]});
      check({3'h0, twoCode, oneCode}, {3'h0, i[2:0], ~i[2:0]});
    end
  endtask
  task automatic testImmediateCodes();
    u_cvs_host_model.wr(TRANSITION_CONTROL_OFFSET, 8'h00);
    for (int c = 0; c < 32; c++) begin
      u_cvs_host_model.wr(CORE_VOLTAGE_CODE_OFFSET, 8'(c));
      go(n);
      check({4'h0, coreOut}, 9'(c));
      check(9'(n), 9'h002);
    end
  endtask
  task automatic testSlowRamp();
    u_cvs_host_model.wr(CORE_SLEW_SELECT_OFFSET, 8'h00);
    u_cvs_host_model.wr(CORE_VOLTAGE_CODE_OFFSET, 8'h1d);
    go(n);
    check({4'h0, coreOut}, 9'h01d);
    check({8'h00, n >= 17 && n <= 35}, 9'h001);
    u_cvs_host_model.wr(CORE_SLEW_SELECT_OFFSET, 8'h06);
    u_cvs_host_model.wr(CORE_VOLTAGE_CODE_OFFSET, 8'h1a);
    go(n);
    check({4'h0, coreOut}, 9'h01a);
    check({8'h00, n >= 3 && n <= 6}, 9'h001);
  endtask
  task automatic testEventsAndPin();
    for (int i = 0; i < 4; i++) begin
      u_cvs_host_model.wr(CORE_VOLTAGE_CODE_OFFSET, 8'h03);
      u_cvs_host_model.wr(TRANSITION_CONTROL_OFFSET, 8'h00);
      evt[i] = 1'b1;
      repeat (5) @(negedge sys_clk);
      evt[i] = 1'b0;
      repeat (5) @(negedge sys_clk);
      rdchk(CORE_VOLTAGE_CODE_OFFSET, 8'h14);
      rdchk(TRANSITION_CONTROL_OFFSET, 8'h40);
    end
    setPin = 1'b0;
    repeat (5) @(negedge sys_clk);
    check({4'h0, coreOut}, 9'h010);
    setPin = 1'b1;
    repeat (5) @(negedge sys_clk);
    check({4'h0, coreOut}, 9'h01f);
  endtask
  task automatic testPreselect();
    logic [31:0] expAll = 32'h77331100;
    for (int p = 0; p < 4; p++) begin
      sys_rst = 1'b1;
      {pinA, pinB} = 2'(p);
      repeat (10) @(negedge sys_clk);
      sys_rst = 1'b0;
      rdchk(LINEAR_REGULATOR_VOLTAGE_CONTROL_OFFSET, expAll[8*p +: 8]);
      rdchk(CORE_VOLTAGE_CODE_OFFSET, 8'h14);
      check({4'h0, coreOut}, 9'h01f);
    end
  endtask
  // ------
  // Clock, timeout and main sequence
  // ------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    sys_rst = 1'b1;
    evt = 4'h0;
    pinA = 1'b1;
    pinB = 1'b0;
    setPin = 1'b1;
    repeat (10) @(negedge sys_clk);
    sys_rst = 1'b0;
    testResetValues();
    testAccess();
    testImmediateCodes();
    testSlowRamp();
    testEventsAndPin();
    testPreselect();
    end_of_test();
  end
endmodule
